//--- logic/audio_clock_pkg.sv
// Constants shared by the field locked audio clock generator
package audio_clock_pkg;
  localparam int          CLK_HZ            = 20_000_000;
  localparam int          ACC_WIDTH         = 23;
  localparam int          TARGET_WIDTH      = 18;
  localparam int          NOMINAL_WIDTH     = 22;
  localparam int          DIV_WIDTH         = 6;
  localparam int          TRIM_WIDTH        = 16;
  localparam logic [15:0] TRIM_MAX          = 16'h3FFF;
  localparam logic [15:0] TRIM_MIN          = 16'hC001;

  localparam logic [7:0]  OFS_TARGET_LOW    = 8'h30;
  localparam logic [7:0]  OFS_TARGET_MID    = 8'h31;
  localparam logic [7:0]  OFS_TARGET_HIGH   = 8'h32;
  localparam logic [7:0]  OFS_NOMINAL_LOW   = 8'h34;
  localparam logic [7:0]  OFS_NOMINAL_MID   = 8'h35;
  localparam logic [7:0]  OFS_NOMINAL_HIGH  = 8'h36;
  localparam logic [7:0]  OFS_BIT_DIV       = 8'h38;
  localparam logic [7:0]  OFS_CHAN_DIV      = 8'h39;
  localparam logic [7:0]  OFS_CONTROL       = 8'h3A;

  localparam int          CTL_LOOP_OPEN     = 3;
  localparam int          CTL_VREF_EXT      = 2;
  localparam int          CTL_CHAN_EDGE     = 1;
  localparam int          CTL_BIT_EDGE      = 0;

  localparam logic [17:0] RST_TARGET        = 18'h3C000;
  localparam logic [21:0] RST_NOMINAL       = 22'h30FBCE;
  localparam logic [5:0]  RST_BIT_DIV       = 6'h03;
  localparam logic [5:0]  RST_CHAN_DIV      = 6'h10;
  localparam logic [3:0]  RST_CONTROL       = 4'h0;
endpackage

//--- logic/clock_divider_chain.sv
// Bit clock and channel clock dividers driven by the external master clock
`timescale 1ns/1ns
module clock_divider_chain (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        master_audio_clock_in,
  divider_cfg_if.sink      cfg,
  output logic             serial_bit_clock_out,
  output logic             left_right_clock_out
);
  logic       mclk_q;
  logic       mclk_edge;
  logic [5:0] bit_cnt_q;
  logic       bit_toggle;
  logic       chan_edge;
  logic [5:0] chan_cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mclk_q <= 1'b0;
    end else begin
      mclk_q <= master_audio_clock_in;
    end
  end

  // Rising edge when the select is 1, falling edge when 0
  assign mclk_edge = cfg.bit_clock_edge_select ? (master_audio_clock_in & ~mclk_q)
                                               : (~master_audio_clock_in & mclk_q); // [RL10]
  assign bit_toggle = mclk_edge && (bit_cnt_q >= cfg.bit_clock_divider_value);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q            <= 6'h00;
      serial_bit_clock_out <= 1'b0;
    end else if (mclk_edge) begin
      if (bit_toggle) begin
        bit_cnt_q            <= 6'h00;
        serial_bit_clock_out <= ~serial_bit_clock_out; // [RL5]
      end else begin
        bit_cnt_q <= bit_cnt_q + 6'h01;
      end
    end
  end

  assign chan_edge = bit_toggle && (cfg.channel_clock_edge_select ? ~serial_bit_clock_out
                                                                  : serial_bit_clock_out); // [RL9]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_cnt_q           <= 6'h00;
      left_right_clock_out <= 1'b0;
    end else if (chan_edge && cfg.channel_clock_divider_value != 6'h00) begin
      if (chan_cnt_q >= cfg.channel_clock_divider_value - 6'h01) begin
        chan_cnt_q           <= 6'h00;
        left_right_clock_out <= ~left_right_clock_out; // [RL6]
      end else begin
        chan_cnt_q <= chan_cnt_q + 6'h01;
      end
    end
  end

  property p_bit_on_edge;
    @(posedge clk) disable iff (!rst_n)
    $changed(serial_bit_clock_out) |->
      ($past(cfg.bit_clock_edge_select) ? $rose(mclk_q) : $fell(mclk_q));
  endproperty
  a_bit_on_edge: assert property (p_bit_on_edge) else $error("bit clock on wrong edge"); // [RL10]

  property p_chan_on_edge;
    @(posedge clk) disable iff (!rst_n)
    $changed(left_right_clock_out) |->
      ($past(cfg.channel_clock_edge_select) ? $rose(serial_bit_clock_out)
                                            : $fell(serial_bit_clock_out));
  endproperty
  a_chan_on_edge: assert property (p_chan_on_edge) else $error("channel clock wrong edge"); // [RL9]

  property p_bit_count;
    @(posedge clk) disable iff (!rst_n)
    $changed(serial_bit_clock_out) |-> $past(bit_cnt_q) >= $past(cfg.bit_clock_divider_value);
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("bit clock toggled early"); // [RL5]

  property p_chan_count;
    @(posedge clk) disable iff (!rst_n)
    $changed(left_right_clock_out) |->
      ($past(chan_cnt_q) + 6'h01) >= $past(cfg.channel_clock_divider_value);
  endproperty
  a_chan_count: assert property (p_chan_count) else $error("channel clock toggled early"); // [RL6]

  c_chan_toggle: cover property (@(posedge clk) disable iff (!rst_n)
    $changed(left_right_clock_out));
endmodule

//--- logic/divider_cfg_if.sv
// Divider settings passed from the register file to the divider chain
`timescale 1ns/1ns
interface divider_cfg_if;
  logic [5:0] bit_clock_divider_value;
  logic [5:0] channel_clock_divider_value;
  logic       bit_clock_edge_select;
  logic       channel_clock_edge_select;
  modport src  (output bit_clock_divider_value, output channel_clock_divider_value,
                output bit_clock_edge_select, output channel_clock_edge_select);
  modport sink (input bit_clock_divider_value, input channel_clock_divider_value,
                input bit_clock_edge_select, input channel_clock_edge_select);
endinterface

//--- logic/field_locked_audio_clock_gen.sv
// Field locked audio master clock generator with register file and dividers
// What this block does
// [RL1] The master clock is synthesized from the block clock, the same crystal reference as video.
// [RL2] The master clock is locked to the field rate so each field holds a fixed clock count.
// [RL3] An 18-bit target of master clocks per field is written over three byte registers.
// [RL4] A 22-bit nominal increment over three byte registers sets the master clock rate.
// [RL5] The bit clock is the master clock input divided by (divider + 1) times 2.
// [RL6] The channel clock is the bit clock divided by divider times 2.
// [RL7] The loop mode bit gives closed locking at 0 and free running nominal rate at 1.
// [RL8] The vertical reference bit picks the internal reference at 0 and external at 1.
// [RL9] The channel clock edge bit moves it on bit clock falling edges at 0, rising at 1.
// [RL10] The bit clock edge bit moves it on master input falling edges at 0, rising at 1.
// [RL11] The board may loop the master clock output back to the input or clean it externally.
// [RL12] The board straps the crystal to one of two supported frequencies at reset.
// [RL13] A phase accumulator is trimmed in closed mode so the field count meets the target.
`timescale 1ns/1ns
module field_locked_audio_clock_gen
  import audio_clock_pkg::*;
#(
  parameter int ACC_W  = ACC_WIDTH,
  parameter int TRIM_W = TRIM_WIDTH
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        internal_vsync,
  input  wire logic        external_vsync,
  input  wire logic        master_audio_clock_in,
  output logic             master_audio_clock_out,
  output logic             serial_bit_clock_out,
  output logic             left_right_clock_out,
  output logic      [17:0] measured_clocks_per_field
);
  logic [17:0]       clocks_per_field_target;
  logic [21:0]       nominal_phase_increment;
  logic [5:0]        bit_div_q;
  logic [5:0]        chan_div_q;
  logic [3:0]        control_q;
  logic              loop_open_select;
  logic              vertical_reference_select;
  logic [ACC_W-1:0]  acc_q;
  logic [ACC_W-1:0]  inc_eff;
  logic [23:0]       inc_sum;
  logic [TRIM_W-1:0] trim_q;
  logic              msb_q;
  logic              mclk_rise;
  logic [17:0]       count_q;
  logic [17:0]       count_now;
  logic              field_pulse;
  logic [7:0]        rdata_d;

  divider_cfg_if cfg_if ();

  assign loop_open_select          = control_q[CTL_LOOP_OPEN];
  assign vertical_reference_select = control_q[CTL_VREF_EXT];

  // Byte register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clocks_per_field_target <= RST_TARGET;
      nominal_phase_increment <= RST_NOMINAL;
      bit_div_q               <= RST_BIT_DIV;
      chan_div_q              <= RST_CHAN_DIV;
      control_q               <= RST_CONTROL;
    end else if (reg_write) begin
      case (reg_addr)
        OFS_TARGET_LOW:   clocks_per_field_target[7:0]   <= reg_wdata; // [RL3]
        OFS_TARGET_MID:   clocks_per_field_target[15:8]  <= reg_wdata; // [RL3]
        OFS_TARGET_HIGH:  clocks_per_field_target[17:16] <= reg_wdata[1:0]; // [RL3]
        OFS_NOMINAL_LOW:  nominal_phase_increment[7:0]   <= reg_wdata; // [RL4]
        OFS_NOMINAL_MID:  nominal_phase_increment[15:8]  <= reg_wdata; // [RL4]
        OFS_NOMINAL_HIGH: nominal_phase_increment[21:16] <= reg_wdata[5:0]; // [RL4]
        OFS_BIT_DIV:      bit_div_q                      <= reg_wdata[5:0];
        OFS_CHAN_DIV:     chan_div_q                     <= reg_wdata[5:0];
        OFS_CONTROL:      control_q                      <= reg_wdata[3:0];
        default:          control_q                      <= control_q;
      endcase
    end
  end

  // Read back, unused bits and unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      OFS_TARGET_LOW:   rdata_d = clocks_per_field_target[7:0];
      OFS_TARGET_MID:   rdata_d = clocks_per_field_target[15:8];
      OFS_TARGET_HIGH:  rdata_d = {6'h00, clocks_per_field_target[17:16]};
      OFS_NOMINAL_LOW:  rdata_d = nominal_phase_increment[7:0];
      OFS_NOMINAL_MID:  rdata_d = nominal_phase_increment[15:8];
      OFS_NOMINAL_HIGH: rdata_d = {2'h0, nominal_phase_increment[21:16]};
      OFS_BIT_DIV:      rdata_d = {2'h0, bit_div_q};
      OFS_CHAN_DIV:     rdata_d = {2'h0, chan_div_q};
      OFS_CONTROL:      rdata_d = {4'h0, control_q};
      default:          rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end
  end

  // Effective increment: nominal plus loop trim, clamped at zero
  assign inc_sum = {2'h0, nominal_phase_increment} + {{(24-TRIM_W){trim_q[TRIM_W-1]}}, trim_q};

  always_comb begin
    if (loop_open_select) begin
      inc_eff = {1'b0, nominal_phase_increment}; // [RL7]
    end else if (inc_sum[23]) begin
      inc_eff = '0;
    end else begin
      inc_eff = inc_sum[ACC_W-1:0]; // [RL13]
    end
  end

  // Phase accumulator on the crystal clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      msb_q <= 1'b0;
    end else begin
      acc_q <= acc_q + inc_eff; // [RL1] [RL4]
      msb_q <= acc_q[ACC_W-1];
    end
  end

  assign master_audio_clock_out = acc_q[ACC_W-1]; // [RL1]
  assign mclk_rise              = acc_q[ACC_W-1] & ~msb_q;

  field_ref_select u_ref (
    .clk                       (clk),
    .rst_n                     (rst_n),
    .vertical_reference_select (vertical_reference_select),
    .internal_vsync            (internal_vsync),
    .external_vsync            (external_vsync),
    .field_pulse               (field_pulse)
  );

  // Master clock periods counted over one field
  assign count_now = (count_q == 18'h3FFFF) ? count_q : count_q + {17'h00000, mclk_rise};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q                   <= 18'h00000;
      measured_clocks_per_field <= 18'h00000;
    end else if (field_pulse) begin
      count_q                   <= 18'h00000; // [RL2]
      measured_clocks_per_field <= count_now;
    end else begin
      count_q <= count_now;
    end
  end

  // Slow loop: one trim step per field toward the target count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trim_q <= '0;
    end else if (loop_open_select) begin
      trim_q <= '0; // [RL7]
    end else if (field_pulse) begin
      if (count_now < clocks_per_field_target && trim_q != TRIM_MAX) begin
        trim_q <= trim_q + 16'h0001; // [RL2] [RL13]
      end else if (count_now > clocks_per_field_target && trim_q != TRIM_MIN) begin
        trim_q <= trim_q - 16'h0001; // [RL2] [RL13]
      end
    end
  end

  assign cfg_if.bit_clock_divider_value     = bit_div_q; // [RL5]
  assign cfg_if.channel_clock_divider_value = chan_div_q; // [RL6]
  assign cfg_if.bit_clock_edge_select       = control_q[CTL_BIT_EDGE]; // [RL10]
  assign cfg_if.channel_clock_edge_select   = control_q[CTL_CHAN_EDGE]; // [RL9]

  clock_divider_chain u_div (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .master_audio_clock_in (master_audio_clock_in),
    .cfg                   (cfg_if.sink),
    .serial_bit_clock_out  (serial_bit_clock_out),
    .left_right_clock_out  (left_right_clock_out)
  );

  property p_open_nominal;
    @(posedge clk) disable iff (!rst_n)
    loop_open_select |=> acc_q == $past(acc_q) + {1'b0, $past(nominal_phase_increment)};
  endproperty
  a_open_nominal: assert property (p_open_nominal) else $error("open loop not nominal"); // [RL7]

  property p_open_trim_zero;
    @(posedge clk) disable iff (!rst_n)
    loop_open_select |=> trim_q == '0;
  endproperty
  a_open_trim_zero: assert property (p_open_trim_zero) else $error("trim kept in open loop"); // [RL7]

  property p_trim_up;
    @(posedge clk) disable iff (!rst_n)
    (!loop_open_select && field_pulse && count_now < clocks_per_field_target
      && trim_q != TRIM_MAX) |=> trim_q == $past(trim_q) + 16'h0001;
  endproperty
  a_trim_up: assert property (p_trim_up) else $error("trim did not rise on short field"); // [RL13]

  property p_trim_down;
    @(posedge clk) disable iff (!rst_n)
    (!loop_open_select && field_pulse && count_now > clocks_per_field_target
      && trim_q != TRIM_MIN) |=> trim_q == $past(trim_q) - 16'h0001;
  endproperty
  a_trim_down: assert property (p_trim_down) else $error("trim did not fall on long field"); // [RL13]

  property p_trim_hold;
    @(posedge clk) disable iff (!rst_n)
    (!loop_open_select && !field_pulse) |=> $stable(trim_q);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim moved inside a field"); // [RL2]

  property p_field_capture;
    @(posedge clk) disable iff (!rst_n)
    field_pulse |=> (count_q == 18'h00000) && measured_clocks_per_field == $past(count_now);
  endproperty
  a_field_capture: assert property (p_field_capture) else $error("field count not captured"); // [RL2]

  property p_mclk_from_acc;
    @(posedge clk) disable iff (!rst_n)
    $rose(master_audio_clock_out) |-> $past(acc_q[ACC_W-1]) == 1'b0 && $past(inc_eff) != '0;
  endproperty
  a_mclk_from_acc: assert property (p_mclk_from_acc) else $error("master clock without step"); // [RL1]

  property p_target_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_write && reg_addr == OFS_TARGET_HIGH) |=>
      clocks_per_field_target[17:16] == $past(reg_wdata[1:0]);
  endproperty
  a_target_write: assert property (p_target_write) else $error("target high not written"); // [RL3]

  property p_nominal_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_write && reg_addr == OFS_NOMINAL_HIGH) |=>
      nominal_phase_increment[21:16] == $past(reg_wdata[5:0]);
  endproperty
  a_nominal_write: assert property (p_nominal_write) else $error("nominal high not written"); // [RL4]

  property p_rdata_hold;
    @(posedge clk) disable iff (!rst_n)
    !reg_read |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read"); // [RL3]

  property p_control_read;
    @(posedge clk) disable iff (!rst_n)
    (reg_read && reg_addr == OFS_CONTROL) |=> reg_rdata == {4'h0, $past(control_q)};
  endproperty
  a_control_read: assert property (p_control_read) else $error("control read back wrong"); // [RL7]

  property p_bit_div_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_write && reg_addr == OFS_BIT_DIV) |=> bit_div_q == $past(reg_wdata[5:0]);
  endproperty
  a_bit_div_write: assert property (p_bit_div_write) else $error("bit divider not written"); // [RL5]

  property p_chan_div_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_write && reg_addr == OFS_CHAN_DIV) |=> chan_div_q == $past(reg_wdata[5:0]);
  endproperty
  a_chan_div_write: assert property (p_chan_div_write) else $error("chan divider not written"); // [RL6]

  property p_control_write;
    @(posedge clk) disable iff (!rst_n)
    (reg_write && reg_addr == OFS_CONTROL) |=> control_q == $past(reg_wdata[3:0]);
  endproperty
  a_control_write: assert property (p_control_write) else $error("control not written"); // [RL7]

  property p_measured_hold;
    @(posedge clk) disable iff (!rst_n)
    !field_pulse |=> $stable(measured_clocks_per_field);
  endproperty
  a_measured_hold: assert property (p_measured_hold) else $error("field count moved"); // [RL2]

  property p_count_run;
    @(posedge clk) disable iff (!rst_n)
    !field_pulse |=> count_q == $past(count_now);
  endproperty
  a_count_run: assert property (p_count_run) else $error("field counter skipped"); // [RL2]

  property p_closed_step;
    @(posedge clk) disable iff (!rst_n)
    (!loop_open_select && !inc_sum[23]) |=> acc_q == $past(acc_q) + $past(inc_sum[ACC_W-1:0]);
  endproperty
  a_closed_step: assert property (p_closed_step) else $error("closed loop step wrong"); // [RL13]

  property p_trim_range;
    @(posedge clk) disable iff (!rst_n)
    trim_q <= TRIM_MAX || trim_q >= TRIM_MIN;
  endproperty
  a_trim_range: assert property (p_trim_range) else $error("trim out of range"); // [RL13]

  c_trim_up: cover property (@(posedge clk) disable iff (!rst_n)
    !loop_open_select && field_pulse && count_now < clocks_per_field_target);
  c_locked: cover property (@(posedge clk) disable iff (!rst_n)
    field_pulse && count_now == clocks_per_field_target);
  c_ext_ref: cover property (@(posedge clk) disable iff (!rst_n)
    field_pulse && vertical_reference_select);
endmodule

//--- logic/field_ref_select.sv
// Vertical reference selection and field start pulse
`timescale 1ns/1ns
module field_ref_select (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic vertical_reference_select,
  input  wire logic internal_vsync,
  input  wire logic external_vsync,
  output logic      field_pulse
);
  logic ref_now;
  logic ref_q;

  assign ref_now = vertical_reference_select ? external_vsync : internal_vsync; // [RL8]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= ref_now;
    end
  end

  assign field_pulse = ref_now & ~ref_q;

  property p_ext_ref;
    @(posedge clk) disable iff (!rst_n)
    (field_pulse && vertical_reference_select && $stable(vertical_reference_select))
      |-> (external_vsync && !$past(external_vsync));
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("field pulse not from external ref"); // [RL8]

  property p_int_ref;
    @(posedge clk) disable iff (!rst_n)
    (field_pulse && !vertical_reference_select && $stable(vertical_reference_select))
      |-> (internal_vsync && !$past(internal_vsync));
  endproperty
  a_int_ref: assert property (p_int_ref) else $error("field pulse not from internal ref"); // [RL8]
endmodule

//--- sim/audio_far_side_model.sv
// Far side model: board loopback of the master clock or a slow external master clock
`timescale 1ns/1ns
module audio_far_side_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic loop_back,
  input  wire logic master_audio_clock_out,
  output logic      master_audio_clock_in
);
  logic [2:0] slow_q;

  // Clock at an eighth of the reference, as an external analog loop would hand back
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_q <= 3'h0;
    end else begin
      slow_q <= slow_q + 3'h1;
    end
  end

  // Board loopback of the generated master clock
  assign master_audio_clock_in = loop_back ? master_audio_clock_out : slow_q[2];
endmodule

//--- sim/tb_field_locked_audio_clock_gen.sv
// Self-checking testbench for the field locked audio clock generator
`timescale 1ns/1ns
module tb_field_locked_audio_clock_gen;
  import audio_clock_pkg::*;
  localparam logic [7:0] ADDRS [9] = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36,
                                       8'h38, 8'h39, 8'h3A};
  localparam logic [7:0] RESETS [9] = '{RST_TARGET[7:0], RST_TARGET[15:8],
    {6'h00, RST_TARGET[17:16]}, RST_NOMINAL[7:0], RST_NOMINAL[15:8],
    {2'h0, RST_NOMINAL[21:16]}, {2'h0, RST_BIT_DIV}, {2'h0, RST_CHAN_DIV}, {4'h0, RST_CONTROL}};
  localparam logic [7:0] MASKS [9] = '{8'hFF, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h3F,
                                       8'h3F, 8'h3F, 8'h0F};
  // Divider rows: loopback, bit divider, channel divider, edge selects
  localparam logic       LOOPS [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  localparam logic [5:0] BDS [4]   = '{6'h00, 6'h03, 6'h01, 6'h02};
  localparam logic [5:0] LDS [4]   = '{6'h01, 6'h02, 6'h03, 6'h01};
  localparam logic [1:0] EDGES [4] = '{2'h3, 2'h0, 2'h1, 2'h2};

  logic        clk;
  logic        rst_n;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        internal_vsync;
  logic        external_vsync;
  logic        master_audio_clock_in;
  logic        master_audio_clock_out;
  logic        serial_bit_clock_out;
  logic        left_right_clock_out;
  logic [17:0] measured;
  logic        loop_back;
  int          tick;
  int          fails;
  int          comparisons;

  field_locked_audio_clock_gen dut_u (
    .clk                       (clk),
    .rst_n                     (rst_n),
    .reg_write                 (reg_write),
    .reg_read                  (reg_read),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_rdata                 (reg_rdata),
    .internal_vsync            (internal_vsync),
    .external_vsync            (external_vsync),
    .master_audio_clock_in     (master_audio_clock_in),
    .master_audio_clock_out    (master_audio_clock_out),
    .serial_bit_clock_out      (serial_bit_clock_out),
    .left_right_clock_out      (left_right_clock_out),
    .measured_clocks_per_field (measured)
  );

  audio_far_side_model far_u (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .loop_back              (loop_back),
    .master_audio_clock_out (master_audio_clock_out),
    .master_audio_clock_in  (master_audio_clock_in)
  );

  // Crystal reference for the block, one fixed rate for the whole run
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Internal fields every 400 cycles, external every 200
  always @(posedge clk) begin
    #1;
    tick = tick + 1;
    internal_vsync = (tick % 400) < 4;
    external_vsync = (tick % 200) < 4;
  end

  function automatic logic sig(input int i);
    case (i)
      0: return master_audio_clock_in;
      1: return serial_bit_clock_out;
      default: return left_right_clock_out;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_write = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 reg_read = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_read = 1'b0;
    d = reg_rdata;
  endtask

  // Counts rising edges of signal a within one period of signal b
  task automatic count_between(input int b, input int a, output int n);
    int   rises;
    int   guard;
    logic pb;
    logic pa;
    rises = 0;
    guard = 0;
    n = 0;
    while (rises < 2 && guard < 5000) begin
      pb = sig(b);
      pa = sig(a);
      @(posedge clk);
      #2;
      if (rises == 1 && sig(a) && !pa) n++;
      if (sig(b) && !pb) rises++;
      guard++;
    end
    if (guard >= 5000) fails++;
  endtask

  // Waits for signal c to change, then compares the level of signal o
  task automatic edge_level(input int c, input int o, input logic exp);
    int   guard;
    logic pc;
    guard = 0;
    pc = sig(c);
    while (sig(c) == pc && guard < 5000) begin
      @(posedge clk);
      #2;
      guard++;
    end
    if (guard >= 5000) fails++;
    check(32'(sig(o)), 32'(exp));
  endtask

  task automatic test_registers;
    logic [7:0] v;
    for (int i = 0; i < 9; i++) begin
      rd(ADDRS[i], v);
      check(32'(v), 32'(RESETS[i]));
    end
    for (int i = 0; i < 9; i++) begin
      wr(ADDRS[i], 8'hFF);
      rd(ADDRS[i], v);
      check(32'(v), 32'(MASKS[i]));
    end
    wr(8'h33, 8'hFF);
    rd(8'h33, v);
    check(32'(v), 32'h0);
    rd(8'h3B, v);
    check(32'(v), 32'h0);
  endtask

  // Increment of 2^21 gives a master clock period of exactly four cycles
  task automatic test_fields;
    wr(8'h34, 8'h00);
    wr(8'h35, 8'h00);
    wr(8'h36, 8'h20);
    wr(8'h3A, 8'h08);
    repeat (1000) @(posedge clk);
    #2 check(32'(measured), 32'd100);
    wr(8'h30, 8'h64);
    wr(8'h31, 8'h00);
    wr(8'h32, 8'h00);
    wr(8'h3A, 8'h00);
    repeat (1000) @(posedge clk);
    #2 check(32'(measured), 32'd100);
    wr(8'h3A, 8'h0C);
    repeat (1000) @(posedge clk);
    #2 check(32'(measured), 32'd50);
  endtask

  task automatic test_dividers;
    int n;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      #1 loop_back = LOOPS[i];
      wr(8'h38, {2'h0, BDS[i]});
      wr(8'h39, {2'h0, LDS[i]});
      wr(8'h3A, {6'h02, EDGES[i]});
      repeat (300) @(posedge clk);
      count_between(1, 0, n);
      check(32'(n), (32'(BDS[i]) + 32'd1) * 32'd2);
      count_between(2, 1, n);
      check(32'(n), 32'(LDS[i]) * 32'd2);
      if (!LOOPS[i]) begin
        edge_level(1, 0, EDGES[i][0]);
        edge_level(2, 1, EDGES[i][1]);
      end
    end
  endtask

  // Open loop with zero increment must not be trimmed into motion
  task automatic test_open_zero;
    wr(8'h36, 8'h00);
    repeat (1000) @(posedge clk);
    #2 check(32'(measured), 32'd0);
  endtask

  task automatic conclude;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    fails++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    internal_vsync = 1'b0;
    external_vsync = 1'b0;
    loop_back = 1'b1;
    tick = 0;
    fails = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    #2 check({master_audio_clock_out, serial_bit_clock_out, left_right_clock_out, measured}, 0);
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    test_registers();
    test_fields();
    test_dividers();
    test_open_zero();
    conclude();
  end
endmodule
